// file: tb/ca_wdt_asserts.sv
// Port-level assertions for the counter array watchdog.
// Assumes counter_array_watchdog on sys_clk with synchronous rst_n.
`timescale 1ns/1ps
module ca_wdt_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wdt_reset_req
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  rst_pulse_a: assert property ($rose(wdt_reset_req) |=> wdt_reset_req ##1 !wdt_reset_req)
    else $error("reset request pulse length wrong");
  boot_fire_a: assert property ($rose(rst_n) |-> ##[1:4] wdt_reset_req)
    else $error("no reset request after boot");
  w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |=> s_axi_bvalid) else $error("write response late");
  w_busy_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |=> s_axi_awready && s_axi_wready) else $error("write channels not freed");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while busy");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0000_00)
    else $error("read upper bits not zero");
  cover property (wdt_reset_req ##1 !wdt_reset_req);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : ca_wdt_chk
bind counter_array_watchdog ca_wdt_chk chk_u (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wdt_reset_req);

// file: tb/tb_top.sv
// Self-checking bench for the counter array watchdog over AXI4-Lite.
// Assumes the package register map; ext_tick is pulsed only in the tick count test.
`timescale 1ns/1ps
module tb_top;
  import ca_wdt_pkg::*;
  logic sys_clk = 1'h0, rst_n = 1'h0, ext_tick = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v, w;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdt_reset_req, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  int num_errors = 0, n_checks = 0, cyc = 0;
  counter_array_watchdog dut_u (.sys_clk, .rst_n, .ext_tick, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wdt_reset_req, .irq);
  // ==========================================================
  // Clock, timeout and bus tasks
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 12000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Response ready stays high, so every answer is taken at the edge it is seen.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0000_00, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    resp = s_axi_rresp;
  endtask : rd
  // The window between the two reads spans the wait plus two cycles.
  task automatic rate(input logic [7:0] m, input int n, input logic [7:0] e);
    wr(ADDR_MODE, m);
    rd(ADDR_CNT_LO, v);
    repeat (n) @(posedge sys_clk);
    rd(ADDR_CNT_LO, w);
    chk("count rate", e, w - v);
  endtask : rate
  task automatic complete_run();
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // ==========================================================
  // Test sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    rd(ADDR_MODE, v);
    chk("mode at reset", MODE_RESET, v);
    chk("rresp", {6'h00, RESP_OKAY}, {6'h00, resp});
    wr(ADDR_MODE, 8'h00);
    chk("bresp", {6'h00, RESP_OKAY}, {6'h00, resp});
    wr(8'h40, 8'h00);
    chk("bresp unmapped", {6'h00, RESP_SLVERR}, {6'h00, resp});
    rd(8'h40, v);
    chk("rresp unmapped", {6'h00, RESP_SLVERR}, {6'h00, resp});
    chk("rdata unmapped", 8'h00, v);
    wr(ADDR_MODE, 8'h40);
    wr(ADDR_MODE, 8'hce);
    rd(ADDR_MODE, v);
    chk("mode frozen", MODE_RESET, v);
    wr(ADDR_CNT_HI, 8'haa);
    rd(ADDR_CNT_HI, v);
    chk("counter high", 8'h00, v);
    wr(ADDR_M4_MODE, 8'h00);
    rd(ADDR_M4_MODE, v);
    chk("module four mode", M4_SWTIMER, v);
    rd(ADDR_CTRL, v);
    chk("run bit", 8'h00, v);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CNT_LO, v);
    repeat (50) @(posedge sys_clk);
    rd(ADDR_CNT_LO, w);
    chk("counter runs", 8'h01, {7'h00, v != w});
    wr(ADDR_OFFSET, 8'h01);
    wr(ADDR_UPDATE, 8'hee);
    rd(ADDR_UPDATE, v);
    chk("update reload", 8'h01, v);
    rd(ADDR_IRQ_STAT, v);
    chk("status", 8'h03, v);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_UPDATE, 8'h00);
    repeat (3) @(posedge sys_clk);
    chk("irq masked", 8'h00, {7'h00, irq});
    rd(ADDR_IRQ_STAT, v);
    chk("service status", 8'h02, v);
    // The counter high byte needs 3072 cycles at the divide-by-12 rate to reach 1.
    for (int i = 0; i < 4000 && !wdt_reset_req; i++) @(posedge sys_clk);
    chk("reset request", 8'h01, {7'h00, wdt_reset_req});
    repeat (3) @(posedge sys_clk);
    chk("irq raised", 8'h01, {7'h00, irq});
    wr(ADDR_MODE, 8'h00);
    rd(ADDR_IRQ_STAT, v);
    chk("match status", 8'h01, v);
    repeat (3) @(posedge sys_clk);
    chk("irq cleared", 8'h00, {7'h00, irq});
    rd(ADDR_M4_MODE, v);
    chk("module four mode kept", M4_SWTIMER, v);
    wr(ADDR_CTRL, 8'h40);
    rd(ADDR_CTRL, v);
    chk("run bit set", 8'h40, v);
    rate(8'h0e, 20, 8'h16);
    rate(8'h02, 38, 8'h0a);
    rate(8'h00, 34, 8'h03);
    wr(ADDR_MODE, 8'h04);
    rd(ADDR_CNT_LO, v);
    repeat (5) begin
      ext_tick <= 1'h1;
      repeat (2) @(posedge sys_clk);
      ext_tick <= 1'h0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
    rd(ADDR_CNT_LO, w);
    chk("tick count", 8'h05, w - v);
    // A second reset in mid-run must arm the watchdog again.
    rst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    rd(ADDR_MODE, v);
    chk("mode after reset", MODE_RESET, v);
    rd(ADDR_CTRL, v);
    chk("run bit after reset", 8'h00, v);
    complete_run();
  end
endmodule : tb_top

// file: verilog/ca_wdt_pkg.sv
// Constants for the counter array watchdog: register map, field layout,
// reset values and reset request pulse timing.
// Assumes an AXI4-Lite master with 32-bit data on the system clock.
package ca_wdt_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
  localparam logic [7:0] ADDR_M4_MODE = 8'h10;
  localparam logic [7:0] ADDR_OFFSET = 8'h14;
  localparam logic [7:0] ADDR_UPDATE = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  // ==========================================================
  // Counter mode and control register fields
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_WDT_BIT = 6;
  localparam int MODE_CPS_LSB = 1;
  localparam int MODE_CPS_W = 3;
  localparam int CTRL_RUN_BIT = 6;
  // ==========================================================
  // Reset values and fixed encodings
  localparam logic [7:0] MODE_RESET = 8'h40;
  localparam logic [7:0] M4_SWTIMER = 8'h48;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [3:0] PRESC_12 = 4'hb;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ==========================================================
  // Timing: reset request pulse length
  localparam int RST_PULSE_NS = 20;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [1:0] RST_PULSE_CYC = 2'((RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Interrupt status bits
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_SERVICE_BIT = 1;
endpackage : ca_wdt_pkg

// file: verilog/counter_array_watchdog.sv
// Watchdog built from compare module four of a capture counter array.
// Assumes an AXI4-Lite master on sys_clk and a system reset controller
// that takes wdt_reset_req and eventually drives rst_n low.
// How it works
// - A missing service lets the counter reach the update byte and reset follows.
// - Setting the watchdog enable bit turns module four into the watchdog.
// - Module four high byte compares to counter high; low byte holds offset.
// - The watchdog enable bit comes up set after every reset.
// - While enabled, the counter runs whatever the run bit says.
// - While enabled, writes to counter low and high bytes are dropped.
// - While enabled, clock select and idle control bits ignore writes.
// - While enabled, module four mode reads as software timer mode.
// - While enabled, writes to module four mode register are ignored.
// - While enabled, run bit writes do not stop the counter.
// - Run bit reads zero when only the watchdog keeps the counter running.
// - Update byte equal to counter high byte while enabled requests reset.
// - While enabled, any value written to the update register services the watchdog.
// - While enabled, an update write loads counter high byte plus offset into update.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module counter_array_watchdog
  import ca_wdt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ext_tick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wdt_reset_req,
  output logic irq
);

  // ==========================================================
  // State
  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] mode;
    logic run_sw;
    logic [7:0] m4_mode;
    logic [15:0] counter;
    logic [3:0] presc;
    logic [7:0] offset;
    logic [7:0] update;
    logic [1:0] rst_cnt;
    logic rst_req;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
    logic tick_s1;
    logic tick_s2;
    logic tick_d;
    // Readies live in the state so that every bus output leaves a flop directly.
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // ==========================================================
  // Counter clock selection
  // Clock source select: 0 sysclk/12, 1 sysclk/4, 2 external tick edge, others sysclk.
  function automatic logic count_step(input logic [2:0] sel, input logic [3:0] presc,
                                      input logic ext_edge);
    case (sel)
      3'h0: count_step = (presc == PRESC_12);
      3'h1: count_step = (presc[1:0] == 2'h3);
      3'h2: count_step = ext_edge;
      default: count_step = 1'b1;
    endcase
  endfunction : count_step

  // ==========================================================
  // Watchdog enable
  logic wdt_on;
  assign wdt_on = st_reg.mode[MODE_WDT_BIT];

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic step;
    logic ev_match;
    logic ev_service;
    logic [7:0] waddr;
    logic [7:0] rbyte;
    step = 1'b0;
    ev_match = 1'b0;
    ev_service = 1'b0;
    waddr = st_reg.aw_addr;
    rbyte = BYTE_ZERO;
    st_next = st_reg;

    // ==========================================================
    // External tick is synchronised before the edge detector sees it.
    // Only the second stage feeds the detector, so a metastable first stage
    // never reaches the counter.
    st_next.tick_s1 = ext_tick;
    st_next.tick_s2 = st_reg.tick_s1;
    st_next.tick_d = st_reg.tick_s2;

    // ==========================================================
    // Counter: runs when software or the watchdog says so.
    // The prescaler runs free whatever the select, so a rate change lands on
    // the next boundary and never leaves a partial count behind.
    // The watchdog forces the count on but leaves run_sw alone, so disabling
    // it hands control back to software unchanged.
    st_next.presc = (st_reg.presc == PRESC_12) ? 4'h0 : st_reg.presc + 4'h1;
    step = count_step(st_reg.mode[MODE_CPS_LSB +: MODE_CPS_W], st_reg.presc,
                      st_reg.tick_s2 & ~st_reg.tick_d);
    if ((st_reg.run_sw || wdt_on) && step) begin
      st_next.counter = st_reg.counter + CNT_ONE;
    end

    // ==========================================================
    // Match detection; the request lasts RST_PULSE_CYC cycles.
    // A match that persists re-arms once the pulse ends, so the reset is asked
    // for again if the first request was ignored.
    if (wdt_on && st_reg.update == st_reg.counter[15:8] &&
        st_reg.rst_cnt == 2'h0) begin
      st_next.rst_cnt = RST_PULSE_CYC;
      ev_match = 1'b1;
    end else if (st_reg.rst_cnt != 2'h0) begin
      st_next.rst_cnt = st_reg.rst_cnt - 2'h1;
    end
    st_next.rst_req = (st_next.rst_cnt != 2'h0);

    // ==========================================================
    // AXI write channels: address and data accepted in either order.
    // Both channels are freed when the write executes; a new item that comes
    // while the response still waits is parked until the response is taken.
    if (s_axi_awvalid && !st_reg.aw_full) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
      waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_full) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata[7:0];
      st_next.w_lane0 = s_axi_wstrb[0];
    end
    if (st_next.aw_full && st_next.w_full && !st_reg.bvalid) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      if (!st_next.w_lane0) begin
        // A write without the low byte lane stores nothing.
      end else if (waddr == ADDR_MODE) begin
        // Only the enable bit stays writable while armed, so a stray write
        // cannot slow the counter and stretch the timeout.
        if (wdt_on) begin
          st_next.mode[MODE_WDT_BIT] = st_next.w_data[MODE_WDT_BIT];
        end else begin
          st_next.mode = st_next.w_data;
          if (st_next.w_data[MODE_WDT_BIT]) begin
            st_next.m4_mode = M4_SWTIMER;
          end
        end
      end else if (waddr == ADDR_CTRL) begin
        st_next.run_sw = st_next.w_data[CTRL_RUN_BIT];
      end else if (waddr == ADDR_CNT_LO) begin
        if (!wdt_on) begin
          st_next.counter[7:0] = st_next.w_data;
        end
      end else if (waddr == ADDR_CNT_HI) begin
        if (!wdt_on) begin
          st_next.counter[15:8] = st_next.w_data;
        end
      end else if (waddr == ADDR_M4_MODE) begin
        if (!wdt_on) begin
          st_next.m4_mode = st_next.w_data;
        end
      end else if (waddr == ADDR_OFFSET) begin
        st_next.offset = st_next.w_data;
      end else if (waddr == ADDR_UPDATE) begin
        if (wdt_on) begin
          // The written value is dropped: the write itself is the service, and
          // the reload always stands offset steps ahead of the counter.
          st_next.update = st_reg.counter[15:8] + st_reg.offset;
          ev_service = 1'b1;
        end else begin
          // With the watchdog off the register is a plain byte for set-up.
          st_next.update = st_next.w_data;
        end
      end else if (waddr == ADDR_IRQ_MASK) begin
        st_next.mask = st_next.w_data[1:0];
      end else if (waddr == ADDR_IRQ_STAT) begin
        // Status clears on read only.
      end else begin
        // Unmapped offsets answer with an error so a bad address is not silent.
        st_next.bresp = RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // ==========================================================
    // AXI read channel.
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      if (s_axi_araddr == ADDR_MODE) begin
        rbyte = st_reg.mode;
      end else if (s_axi_araddr == ADDR_CTRL) begin
        rbyte = BYTE_ZERO;
        // Shows what software asked for, not whether the watchdog forces the count.
        rbyte[CTRL_RUN_BIT] = st_reg.run_sw;
      end else if (s_axi_araddr == ADDR_CNT_LO) begin
        rbyte = st_reg.counter[7:0];
      end else if (s_axi_araddr == ADDR_CNT_HI) begin
        rbyte = st_reg.counter[15:8];
      end else if (s_axi_araddr == ADDR_M4_MODE) begin
        // While the watchdog is on, module four is reported as a software timer whatever was stored.
        rbyte = wdt_on ? M4_SWTIMER : st_reg.m4_mode;
      end else if (s_axi_araddr == ADDR_OFFSET) begin
        rbyte = st_reg.offset;
      end else if (s_axi_araddr == ADDR_UPDATE) begin
        rbyte = st_reg.update;
      end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
        rbyte = {6'h00, st_reg.stat};
        st_next.stat = 2'b00;
      end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
        rbyte = {6'h00, st_reg.mask};
      end else begin
        st_next.rresp = RESP_SLVERR;
      end
      st_next.rdata = {24'h00_0000, rbyte};
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // ==========================================================
    // Events set after the read clear so that a same-cycle event is kept.
    if (ev_match) begin
      st_next.stat[IRQ_MATCH_BIT] = 1'b1;
    end
    if (ev_service) begin
      st_next.stat[IRQ_SERVICE_BIT] = 1'b1;
    end
    st_next.irq = |(st_next.stat & st_next.mask);

    // ==========================================================
    // Reset arms the watchdog, so a program that never reaches its set-up
    // code is still caught.
    if (!rst_n) begin
      st_next = '0;
      st_next.mode = MODE_RESET;
    end
    // Readies are the inverse of the holding flags that they guard.
    st_next.aw_rdy = !st_next.aw_full;
    st_next.w_rdy = !st_next.w_full;
    st_next.ar_rdy = !st_next.rvalid;
  end

  // ==========================================================
  // Register stage
  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  // ==========================================================
  // Outputs
  // The request and the interrupt are registered copies of the state as well.
  assign s_axi_awready = st_reg.aw_rdy;
  assign s_axi_wready = st_reg.w_rdy;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.ar_rdy;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign wdt_reset_req = st_reg.rst_req;
  assign irq = st_reg.irq;

endmodule : counter_array_watchdog
